// File: verilog/rdc_pkg.sv
// package: register map, field layout, decode tables and shared types of the reverse drive config block
package rdc_pkg;
  localparam int ADDR_W = 12;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [7:0] ISD_IDX = 8'h80;
  localparam logic [7:0] REV_IDX = 8'h82;
  localparam logic [ADDR_W-1:0] ISD_ADDR = {2'h0, ISD_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] REV_ADDR = {2'h0, REV_IDX, 2'h0};
  localparam logic [31:0] ISD_RST = 32'h0000_0000;
  localparam logic [31:0] REV_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // initial speed detect word
  localparam int COAST_EN_BIT = 28;
  localparam int REV_EN_BIT = 27;
  localparam int COAST_LSB = 9;
  localparam int BEMF_LSB = 6;
  localparam int HANDOFF_LSB = 2;
  localparam int OLCUR_LSB = 0;
  // reverse drive word
  localparam int A1_LSB = 27;
  localparam int A2_LSB = 23;
  localparam int BRKCUR_LSB = 20;
  localparam int KP_LSB = 10;
  localparam int KI_LSB = 0;
  localparam logic [3:0] A1_NOVAL = 4'hA;
  localparam logic [3:0] A2_NOVAL = 4'hE;

  // coast duration in ms
  localparam logic [13:0] COAST_MS_LUT [16] = '{14'h000A, 14'h0032, 14'h0064, 14'h00C8, 14'h012C, 14'h0190,
    14'h01F4, 14'h02EE, 14'h03E8, 14'h07D0, 14'h0BB8, 14'h0FA0, 14'h1388, 14'h1D4C, 14'h2710, 14'h3A98};
  // standstill back-emf threshold in mV
  localparam logic [10:0] BEMF_MV_LUT [8] = '{11'h032, 11'h04B, 11'h064, 11'h0FA, 11'h1F4, 11'h2EE,
    11'h3E8, 11'h5DC};
  // handoff speed in tenths of a percent of maximum speed
  localparam logic [9:0] HANDOFF_LUT [16] = '{10'h019, 10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096,
    10'h0C8, 10'h0FA, 10'h12C, 10'h190, 10'h1F4, 10'h258, 10'h2BC, 10'h320, 10'h384, 10'h3E8};
  // open loop current cap in units of 0.1 A
  localparam logic [5:0] OLCUR_LUT [4] = '{6'h0F, 6'h19, 6'h23, 6'h32};
  // acceleration in units of 0.01 Hz/s (or Hz/s2); unlisted codes give zero
  localparam logic [19:0] A1_LUT [16] = '{20'h00001, 20'h00005, 20'h00064, 20'h000FA, 20'h001F4, 20'h003E8,
    20'h009C4, 20'h01388, 20'h01D4C, 20'h02710, 20'h00000, 20'h0C350, 20'h124F8, 20'h186A0, 20'h7A120,
    20'hF4240};
  localparam logic [19:0] A2_LUT [16] = '{20'h00000, 20'h00005, 20'h00064, 20'h000FA, 20'h001F4, 20'h003E8,
    20'h009C4, 20'h01388, 20'h01D4C, 20'h02710, 20'h061A8, 20'h0C350, 20'h124F8, 20'h186A0, 20'h00000,
    20'hF4240};
  // active brake bus current limit in units of 0.1 A
  localparam logic [6:0] BRKCUR_LUT [8] = '{7'h05, 7'h0A, 7'h14, 7'h1E, 7'h28, 7'h32, 7'h3C, 7'h46};

  typedef struct packed {
    logic coast_step_on;
    logic reverse_drive_on;
    logic accel_code_bad;
    logic [13:0] coast_ms;
    logic [10:0] standstill_mv;
    logic [9:0] handoff_permille;
    logic [5:0] olcur_da;
    logic [19:0] accel1;
    logic [19:0] accel2;
    logic [6:0] brkcur_da;
    logic [9:0] kp_q7;
    logic [9:0] ki_q9;
  } rdc_dec_t;
endpackage

// File: verilog/rdc_if.sv
// interfaces: register access strobes and configuration words with their decoded settings
`timescale 1ns/1ps
interface rdc_reg_if;
  import rdc_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

interface rdc_cfg_if;
  import rdc_pkg::*;
  logic [31:0] isd;
  logic [31:0] rev;
  rdc_dec_t dec;
  modport dec_side (input isd, rev, output dec);
  modport top (output isd, rev, input dec);
endinterface

// File: verilog/rdc_axi_slave.sv
// AXI4-Lite slave: takes one write and one read at a time and turns them into register strobes
`timescale 1ns/1ps
module rdc_axi_slave import rdc_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  rdc_reg_if.slv rb
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rdc_axi_t;

  rdc_axi_t q;
  rdc_axi_t d;

  always_comb begin
    d = q;
    rb.wr_en = 1'b0;
    rb.wr_addr = q.addr;
    rb.wr_data = q.data;
    rb.wr_strb = q.strb;
    rb.rd_addr = araddr;
    if (awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.data = wdata;
      d.strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    // commit once both halves are held; unmapped addresses store nothing
    if (q.aw_got && q.w_got && !q.bvalid) begin
      rb.wr_en = rb.wr_ok;
      d.bvalid = 1'b1;
      d.bresp = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rb.rd_ok ? rb.rd_data : 32'h0000_0000;
      d.rresp = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
endmodule // rdc_axi_slave

// File: verilog/rdc_decode.sv
// field decoder: turns the two configuration words into scaled settings; coast, handoff, open loop current and acceleration settings are enable-gated
`timescale 1ns/1ps
module rdc_decode import rdc_pkg::*; (
  rdc_cfg_if.dec_side cfg
);
  always_comb begin
    logic rev_on;
    logic [3:0] a1_code;
    logic [3:0] a2_code;
    rev_on = cfg.isd[REV_EN_BIT];
    a1_code = cfg.rev[A1_LSB +: 4];
    a2_code = cfg.rev[A2_LSB +: 4];
    cfg.dec = '0;
    cfg.dec.coast_step_on = cfg.isd[COAST_EN_BIT];
    cfg.dec.reverse_drive_on = rev_on;
    if (cfg.isd[COAST_EN_BIT]) begin // see RQ12
      cfg.dec.coast_ms = COAST_MS_LUT[cfg.isd[COAST_LSB +: 4]]; // see RQ1
    end
    cfg.dec.standstill_mv = BEMF_MV_LUT[cfg.isd[BEMF_LSB +: 3]]; // see RQ2
    // handoff, open loop current and acceleration settings only reach the drive while reverse drive is on
    if (rev_on) begin // see RQ11
      cfg.dec.handoff_permille = HANDOFF_LUT[cfg.isd[HANDOFF_LSB +: 4]]; // see RQ3
      cfg.dec.olcur_da = OLCUR_LUT[cfg.isd[OLCUR_LSB +: 2]]; // see RQ4
      cfg.dec.accel1 = A1_LUT[a1_code]; // see RQ5
      cfg.dec.accel2 = A2_LUT[a2_code]; // see RQ6
      cfg.dec.accel_code_bad = (a1_code == A1_NOVAL) || (a2_code == A2_NOVAL); // see RQ13
    end
    cfg.dec.brkcur_da = BRKCUR_LUT[cfg.rev[BRKCUR_LSB +: 3]]; // see RQ7
    cfg.dec.kp_q7 = cfg.rev[KP_LSB +: 10]; // see RQ8
    cfg.dec.ki_q9 = cfg.rev[KI_LSB +: 10]; // see RQ9
  end
endmodule // rdc_decode

// File: verilog/rdc_top.sv
// top: register bank for initial speed detect and reverse drive settings, with decoded outputs
//
// What this block does
// RQ1 - The 4-bit coast duration code in bits 12 to 9 selects 10 ms at code 0 up to 15 s at code F.
// RQ2 - The 3-bit code in bits 8 to 6 selects the standstill back-emf threshold, 50 mV up to 1500 mV.
// RQ3 - The 4-bit code in bits 5 to 2 selects the reverse drive handoff speed, 2.5 % up to 100 % of maximum.
// RQ4 - Bits 1 to 0 select the reverse drive open loop current cap of 1.5, 2.5, 3.5 or 5.0 A.
// RQ5 - Bits 30 to 27 of the reverse word select the first-order acceleration, 0.01 up to 10000 Hz/s.
// RQ6 - Bits 26 to 23 select the second-order acceleration, 0.0 up to 10000 Hz/s2.
// RQ7 - Bits 22 to 20 select the active brake bus current cap, 0.5 A then 1 A to 7 A in 1 A steps.
// RQ8 - Bits 19 to 10 are the brake proportional gain with seven fraction bits.
// RQ9 - Bits 9 to 0 are the brake integral gain with nine fraction bits.
// RQ10 - After reset the reverse drive word reads all zeros.
// RQ11 - Handoff, open loop current and acceleration settings act only while the reverse drive enable bit is set.
// RQ12 - Coast duration acts only while the coast step enable bit is set.
// RQ13 - Acceleration codes with no listed value are flagged as unsupported and give zero.
`timescale 1ns/1ps
module rdc_top import rdc_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic COAST_STEP_ON,
  output logic REVERSE_DRIVE_ON,
  output logic ACCEL_CODE_BAD,
  output logic [13:0] COAST_MS,
  output logic [10:0] STANDSTILL_MV,
  output logic [9:0] HANDOFF_PERMILLE,
  output logic [5:0] OL_CURRENT_DA,
  output logic [19:0] ACCEL1_CENTI,
  output logic [19:0] ACCEL2_CENTI,
  output logic [6:0] BRAKE_CURRENT_DA,
  output logic [9:0] BRAKE_KP_Q7,
  output logic [9:0] BRAKE_KI_Q9
);
  typedef struct packed {
    logic [31:0] isd;
    logic [31:0] rev;
    rdc_dec_t out;
  } rdc_state_t;

  rdc_state_t q;
  rdc_state_t d;
  logic [31:0] wmask;

  rdc_reg_if rb ();
  rdc_cfg_if cfg ();

  rdc_axi_slave u_axi (
    .clk(MCLK),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rb(rb.slv)
  );

  rdc_decode u_dec (
    .cfg(cfg.dec_side)
  );

  // byte lane mask from the write strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{rb.wr_strb[b]}};
  end

  assign rb.wr_ok = (rb.wr_addr == ISD_ADDR) || (rb.wr_addr == REV_ADDR);
  assign rb.rd_ok = (rb.rd_addr == ISD_ADDR) || (rb.rd_addr == REV_ADDR);
  assign rb.rd_data = (rb.rd_addr == ISD_ADDR) ? q.isd : q.rev;
  assign cfg.isd = q.isd;
  assign cfg.rev = q.rev;

  always_comb begin
    d = q;
    if (rb.wr_en && (rb.wr_addr == ISD_ADDR)) begin
      d.isd = (q.isd & ~wmask) | (rb.wr_data & wmask);
    end
    if (rb.wr_en && (rb.wr_addr == REV_ADDR)) begin
      d.rev = (q.rev & ~wmask) | (rb.wr_data & wmask);
    end
    // decoded settings are registered so every output leaves a flip-flop
    d.out = cfg.dec;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      q.isd <= ISD_RST;
      q.rev <= REV_RST; // see RQ10
      q.out <= '0;
    end else begin
      q <= d;
    end
  end

  assign COAST_STEP_ON = q.out.coast_step_on;
  assign REVERSE_DRIVE_ON = q.out.reverse_drive_on;
  assign ACCEL_CODE_BAD = q.out.accel_code_bad;
  assign COAST_MS = q.out.coast_ms;
  assign STANDSTILL_MV = q.out.standstill_mv;
  assign HANDOFF_PERMILLE = q.out.handoff_permille;
  assign OL_CURRENT_DA = q.out.olcur_da;
  assign ACCEL1_CENTI = q.out.accel1;
  assign ACCEL2_CENTI = q.out.accel2;
  assign BRAKE_CURRENT_DA = q.out.brkcur_da;
  assign BRAKE_KP_Q7 = q.out.kp_q7;
  assign BRAKE_KI_Q9 = q.out.ki_q9;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_coast_long_code: assert property ( // see RQ1
    (q.isd[COAST_EN_BIT] && q.isd[COAST_LSB +: 4] == 4'hF) |=> COAST_MS == 14'h3A98)
    else $error("coast code F did not give 15 s");
  a_coast_short_code: assert property ( // see RQ1
    (q.isd[COAST_EN_BIT] && q.isd[COAST_LSB +: 4] == 4'h0) |=> COAST_MS == 14'h000A)
    else $error("coast code 0 did not give 10 ms");
  a_coast_gate_off: assert property ( // see RQ12
    !q.isd[COAST_EN_BIT] |=> (COAST_MS == 14'h0000 && !COAST_STEP_ON))
    else $error("coast duration active while coast step disabled");
  a_standstill_top: assert property ( // see RQ2
    q.isd[BEMF_LSB +: 3] == 3'h7 |=> STANDSTILL_MV == 11'h5DC)
    else $error("standstill code 7 did not give 1500 mV");
  a_handoff_low: assert property ( // see RQ3
    (q.isd[REV_EN_BIT] && q.isd[HANDOFF_LSB +: 4] == 4'h0) |=> HANDOFF_PERMILLE == 10'h019)
    else $error("handoff code 0 did not give 2.5 percent");
  a_olcur_high: assert property ( // see RQ4
    (q.isd[REV_EN_BIT] && q.isd[OLCUR_LSB +: 2] == 2'h3) |=> OL_CURRENT_DA == 6'h32)
    else $error("open loop current code 3 did not give 5.0 A");
  a_accel1_gap: assert property ( // see RQ13
    (q.isd[REV_EN_BIT] && q.rev[A1_LSB +: 4] == 4'hA) |=> (ACCEL_CODE_BAD && ACCEL1_CENTI == 20'h00000))
    else $error("unlisted first-order code not flagged");
  a_accel1_low: assert property ( // see RQ5
    (q.isd[REV_EN_BIT] && q.rev[A1_LSB +: 4] == 4'h0) |=> ACCEL1_CENTI == 20'h00001)
    else $error("first-order code 0 did not give 0.01 Hz/s");
  a_accel2_top: assert property ( // see RQ6
    (q.isd[REV_EN_BIT] && q.rev[A2_LSB +: 4] == 4'hF) |=> ACCEL2_CENTI == 20'hF4240)
    else $error("second-order code F did not give 10000 Hz/s2");
  // the decoded outputs trail reset release by one registered cycle
  a_brake_cur_low: assert property ( // see RQ7
    (RST_N && q.rev[BRKCUR_LSB +: 3] == 3'h0) |=> BRAKE_CURRENT_DA == 7'h05)
    else $error("brake current code 0 did not give 0.5 A");
  a_gain_follow: assert property ( // see RQ8
    ##1 BRAKE_KP_Q7 == $past(q.rev[KP_LSB +: 10]))
    else $error("proportional gain does not follow its field");
  a_ki_follow: assert property ( // see RQ9
    ##1 BRAKE_KI_Q9 == $past(q.rev[KI_LSB +: 10]))
    else $error("integral gain does not follow its field");
  a_rev_gate_off: assert property ( // see RQ11
    !q.isd[REV_EN_BIT] |=> (HANDOFF_PERMILLE == 10'h000 && OL_CURRENT_DA == 6'h00 && ACCEL1_CENTI == 20'h00000
      && ACCEL2_CENTI == 20'h00000 && !REVERSE_DRIVE_ON))
    else $error("reverse drive settings active while disabled");
  a_rev_reset_zero: assert property (@(posedge MCLK) disable iff (1'b0) // see RQ10
    !RST_N |=> q.rev == 32'h0000_0000)
    else $error("reverse drive word not zero after reset");

  c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == RESP_OKAY);
  c_bad_addr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
  c_rev_active: cover property (REVERSE_DRIVE_ON && HANDOFF_PERMILLE == 10'h3E8);
  c_code_gap: cover property (ACCEL_CODE_BAD);
endmodule // rdc_top

// File: test/reverse_drive_initial_speed_detect_settings_regs_tb.sv
// testbench: register bank and decoded settings of the reverse drive config block over AXI4-Lite
`timescale 1ns/1ps
module reverse_drive_initial_speed_detect_settings_regs_tb;
  import rdc_pkg::*;
  logic MCLK, RST_N;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic COAST_STEP_ON, REVERSE_DRIVE_ON, ACCEL_CODE_BAD;
  logic [13:0] COAST_MS;
  logic [10:0] STANDSTILL_MV;
  logic [9:0] HANDOFF_PERMILLE, BRAKE_KP_Q7, BRAKE_KI_Q9;
  logic [5:0] OL_CURRENT_DA;
  logic [19:0] ACCEL1_CENTI, ACCEL2_CENTI;
  logic [6:0] BRAKE_CURRENT_DA;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] isd_m, rev_m;
  // expected decodes in output units: ms, mV, 0.1 %, 0.1 A, 0.01 Hz/s
  int coast_t [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000, 7500, 10000, 15000};
  int bemf_t [8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
  int hand_t [16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700, 800, 900, 1000};
  int olc_t [4] = '{15, 25, 35, 50};
  // unlisted acceleration codes are expected to give zero
  int a1_t [16] = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 0, 50000, 75000, 100000, 500000, 1000000};
  int a2_t [16] = '{0, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000, 50000, 75000, 100000, 0, 1000000};
  int brk_t [8] = '{5, 10, 20, 30, 40, 50, 60, 70};

  rdc_top i_dut (.*);

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    fails++;
    $display("no answer from the slave at %0t", $time);
    wrap_up();
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[8*b+:8] = d[8*b+:8];
      end
    end
    return o;
  endfunction

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit aw_on = 1;
    bit w_on = 1;
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge MCLK);
      if (aw_on && S_AXI_AWREADY) begin
        aw_on = 0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w_on && S_AXI_WREADY) begin
        w_on = 0;
        S_AXI_WVALID <= 1'b0;
      end
      if (S_AXI_BVALID) begin
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge MCLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARVALID <= 1'b0;
      end
      if (S_AXI_RVALID) begin
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  task automatic chk_dec();
    logic rv, cv;
    logic [3:0] a1, a2;
    rv = isd_m[REV_EN_BIT];
    cv = isd_m[COAST_EN_BIT];
    a1 = rev_m[30:27];
    a2 = rev_m[26:23];
    chk_val(32'(COAST_STEP_ON), 32'(cv));
    chk_val(32'(REVERSE_DRIVE_ON), 32'(rv));
    chk_val(32'(ACCEL_CODE_BAD), 32'(rv && (a1 == 4'hA || a2 == 4'hE)));
    chk_val(32'(COAST_MS), cv ? coast_t[isd_m[12:9]] : 0);
    chk_val(32'(STANDSTILL_MV), bemf_t[isd_m[8:6]]);
    chk_val(32'(HANDOFF_PERMILLE), rv ? hand_t[isd_m[5:2]] : 0);
    chk_val(32'(OL_CURRENT_DA), rv ? olc_t[isd_m[1:0]] : 0);
    chk_val(32'(ACCEL1_CENTI), rv ? a1_t[a1] : 0);
    chk_val(32'(ACCEL2_CENTI), rv ? a2_t[a2] : 0);
    chk_val(32'(BRAKE_CURRENT_DA), brk_t[rev_m[22:20]]);
    chk_val(32'(BRAKE_KP_Q7), 32'(rev_m[19:10]));
    chk_val(32'(BRAKE_KI_Q9), 32'(rev_m[9:0]));
  endtask

  // writes, updates the mirror, then checks the response and the decoded settings
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    if (a === ISD_ADDR) begin
      isd_m = merge(isd_m, d, s);
    end
    if (a === REV_ADDR) begin
      rev_m = merge(rev_m, d, s);
    end
    chk_resp(r, (a === ISD_ADDR || a === REV_ADDR) ? RESP_OKAY : RESP_SLVERR);
    @(posedge MCLK);
    #1;
    chk_dec();
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_val(d, (a === ISD_ADDR) ? isd_m : (a === REV_ADDR) ? rev_m : 32'h0);
    chk_resp(r, (a === ISD_ADDR || a === REV_ADDR) ? RESP_OKAY : RESP_SLVERR);
  endtask

  task automatic end_test(input string n);
    $display("test %s done, mismatches so far %0d", n, fails);
  endtask

  initial begin
    RST_N = 1'b0;
    S_AXI_AWADDR = '0;
    S_AXI_ARADDR = '0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'h0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    isd_m = ISD_RST;
    rev_m = 32'h0;
    void'($urandom(32'hD6CC));
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    chk_dec();
    rd_chk(REV_ADDR);
    rd_chk(ISD_ADDR);
    end_test("reset");
    for (int i = 0; i < 16; i++) begin
      wr_chk(ISD_ADDR, {3'h0, i[1:0] != 2'h3, i[1:0] != 2'h2, 14'($urandom), 4'(i), 3'(i), 4'(15 - i), 2'(i)},
             4'hF);
      rd_chk(ISD_ADDR);
    end
    end_test("speed detect codes");
    for (int i = 0; i < 16; i++) begin
      wr_chk(REV_ADDR, {1'($urandom), 4'(i), 4'(15 - i), 3'(i), 10'($urandom), 10'($urandom)},
             4'hF);
      rd_chk(REV_ADDR);
    end
    wr_chk(REV_ADDR, 32'hFFFF_FFFF, 4'hF);
    wr_chk(ISD_ADDR, 32'h0, 4'hF);
    wr_chk(REV_ADDR, 32'h5700_0000, 4'hF);
    end_test("reverse drive codes");
    for (int s = 0; s < 16; s++) begin
      wr_chk((s % 2) ? REV_ADDR : ISD_ADDR, $urandom, 4'(s));
      rd_chk(REV_ADDR);
      rd_chk(ISD_ADDR);
    end
    end_test("byte strobes");
    wr_chk(12'h204, 32'hFFFF_FFFF, 4'hF);
    wr_chk(12'hFFC, 32'hA5A5_A5A5, 4'hF);
    rd_chk(12'h204);
    rd_chk(12'h000);
    rd_chk(REV_ADDR);
    rd_chk(ISD_ADDR);
    end_test("unmapped");
    for (int i = 0; i < 24; i++) begin
      wr_chk(($urandom % 2) ? REV_ADDR : ISD_ADDR, $urandom, 4'($urandom));
      rd_chk(($urandom % 2) ? REV_ADDR : ISD_ADDR);
    end
    end_test("random");
    wr_chk(REV_ADDR, 32'hFFFF_FFFF, 4'hF);
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    isd_m = ISD_RST;
    rev_m = REV_RST;
    repeat (2) @(posedge MCLK);
    #1;
    chk_dec();
    rd_chk(REV_ADDR);
    rd_chk(ISD_ADDR);
    end_test("second reset");
    wrap_up();
  end
endmodule // reverse_drive_initial_speed_detect_settings_regs_tb
